// File: core/sat_pkg.sv
// Purpose: shared constants for the SSI absolute position transmitter
// Assumes: 100 MHz core clock
// Notes: times are kept in their own units, cycle counts derived here
package sat_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned FIELD_MAX = 16;
  localparam int unsigned FLD_W = 5;
  localparam int unsigned CNT_W = 6;
  // Monoflop time; must exceed the longest clock half-period (5 us)
  localparam int unsigned TM_US = 20;
  localparam int unsigned TM_CYC = TM_US * CLK_MHZ;
  localparam int unsigned TM_W = 12;
  // Position sample refresh period, well below the 100 us cycle time
  localparam int unsigned SMP_US = 10;
  localparam int unsigned SMP_CYC = SMP_US * CLK_MHZ;
  localparam int unsigned SMP_W = 11;
  // Register byte addresses
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] POS_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  // Control field positions
  localparam int unsigned GRAY_BIT = 0;
  localparam int unsigned ST_LSB = 8;
  localparam int unsigned MT_LSB = 16;
  // Control reset values
  localparam logic CTRL_GRAY_RST = 1'b1;
  localparam logic [FLD_W-1:0] CTRL_ST_RST = 5'h0D;
  localparam logic [FLD_W-1:0] CTRL_MT_RST = 5'h0C;
  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_SHIFT = 3'b010,
    LINK_TAIL = 3'b100
  } sat_link_e;
endpackage : sat_pkg

// File: core/sat_pos_if.sv
// Purpose: carries configuration and position between core and counter
// Assumes: both ends on the core clock
// Notes: none
`timescale 1ns/1ps
interface sat_pos_if;
  logic step;
  logic cw;
  logic dir_down;
  logic zero_fall;
  logic gray;
  logic [5:0] nbits;
  logic [31:0] position;
  logic [31:0] sample;
  modport prov (
    input step, cw, dir_down, zero_fall, gray, nbits,
    output position, sample
  );
  modport user (
    output step, cw, dir_down, zero_fall, gray, nbits,
    input position, sample
  );
endinterface : sat_pos_if

// File: core/sat_pos.sv
// Purpose: multiturn position counter with coded periodic sample
// Assumes: step and cw come from sensor logic on the core clock
// Notes: counter wraps within the configured n bits
`timescale 1ns/1ps
module sat_pos (
  input wire logic clk_i,
  input wire logic rst_n_i,
  sat_pos_if.prov p
);
  typedef struct packed {
    logic [31:0] pos;
    logic [31:0] smp;
    logic [sat_pkg::SMP_W-1:0] tick;
  } sat_pos_s;

  sat_pos_s q;
  sat_pos_s d;

  function automatic logic [31:0] sat_mask(input logic [5:0] n);
    sat_mask = (n >= 6'd32) ? 32'hFFFFFFFF : ((32'h1 << n) - 32'h1);
  endfunction : sat_mask

  logic up;

  always_comb begin
    d = q;
    up = p.cw ^ p.dir_down;
    if (p.zero_fall) begin
      d.pos = 32'h0;
    end else if (p.step) begin
      if (up) begin
        d.pos = (q.pos + 32'h1) & sat_mask(p.nbits);
      end else begin
        d.pos = (q.pos - 32'h1) & sat_mask(p.nbits);
      end
    end
    if (q.tick == sat_pkg::SMP_W'(sat_pkg::SMP_CYC - 1)) begin
      d.tick = '0;
      if (p.gray) begin
        d.smp = q.pos ^ (q.pos >> 1);
      end else begin
        d.smp = q.pos;
      end
    end else begin
      d.tick = q.tick + sat_pkg::SMP_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign p.position = q.pos;
  assign p.sample = q.smp;
endmodule : sat_pos

// File: core/sat_ssi_tx.sv
// Purpose: SSI transmit side of a multiturn absolute encoder
// Assumes: link clock, direction and zero-set pins are asynchronous
// Notes: registers over Avalon-MM, one wait state per access
// Behaviour
// - Idle: clock high, data held high
// - First falling edge captures position word
// - MSB driven at first rising edge
// - Each further rising edge sends next bit
// - After LSB, data low until monoflop expires
// - Monoflop restarts on every falling edge
// - Frame carries exactly n data bits
// - Single-turn, multiturn each 16 bits maximum
// - Continued clocking repeats the captured word
// - Late pulse n+1 starts fresh capture
// - Gray or binary output code selectable
// - Direction input high makes cw count down
// - Direction change effective within 250 ms
// - Zero-set on falling edge of input
`timescale 1ns/1ps
module sat_ssi_tx (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ssi_clk_i,
  output logic ssi_data_o,
  input wire logic dir_sel_i,
  input wire logic zero_set_i,
  input wire logic step_i,
  input wire logic cw_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  localparam int unsigned FW = sat_pkg::FLD_W;
  localparam int unsigned CW = sat_pkg::CNT_W;
  localparam int unsigned TW = sat_pkg::TM_W;

  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic dir_s1;
    logic dir_s2;
    logic zs_s1;
    logic zs_s2;
    logic zs_s3;
    sat_pkg::sat_link_e state;
    logic [31:0] word;
    logic [31:0] shreg;
    logic [CW-1:0] bitcnt;
    logic [TW-1:0] mono;
    logic data;
    logic ring;
    logic gap;
    logic gray;
    logic [FW-1:0] st_bits;
    logic [FW-1:0] mt_bits;
    logic wait_n;
    logic wreq;
    logic [31:0] rdata;
  } sat_top_s;

  sat_top_s q;
  sat_top_s d;

  logic [1:0] rst_sync_q;
  logic rst_n;

  sat_pos_if pif();

  // Reset is asserted at once but released only on the core clock
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic [FW-1:0] sat_clamp(input logic [FW-1:0] v);
    if (v > FW'(sat_pkg::FIELD_MAX)) begin
      sat_clamp = FW'(sat_pkg::FIELD_MAX);
    end else begin
      sat_clamp = v;
    end
  endfunction : sat_clamp

  logic [CW-1:0] nbits;
  logic clk_fall;
  logic clk_rise;
  logic mono_done;
  logic req;
  logic acc;
  logic [31:0] aligned;

  always_comb begin
    nbits = CW'(sat_clamp(q.st_bits)) + CW'(sat_clamp(q.mt_bits));
    if (nbits == '0) begin
      nbits = CW'(1);
    end
  end

  assign pif.step = step_i;
  assign pif.cw = cw_i;
  assign pif.dir_down = q.dir_s2;
  assign pif.zero_fall = q.zs_s3 & ~q.zs_s2;
  assign pif.gray = q.gray;
  assign pif.nbits = nbits;

  sat_pos u_pos (
    .clk_i(clock_i),
    .rst_n_i(rst_n),
    .p(pif.prov)
  );

  assign clk_fall = q.clk_s3 & ~q.clk_s2;
  assign clk_rise = ~q.clk_s3 & q.clk_s2;
  assign mono_done = (q.mono == TW'(1));
  assign req = avs_read_i | avs_write_i;
  // Writes land on the accept edge, where waitrequest is seen low
  assign acc = req & q.wait_n;
  // Left-align the word so the MSB of n bits sits in bit 31
  assign aligned = pif.sample << (CW'(32) - nbits);

  always_comb begin
    d = q;
    d.clk_s1 = ssi_clk_i;
    d.clk_s2 = q.clk_s1;
    d.clk_s3 = q.clk_s2;
    d.dir_s1 = dir_sel_i;
    d.dir_s2 = q.dir_s1;
    d.zs_s1 = zero_set_i;
    d.zs_s2 = q.zs_s1;
    d.zs_s3 = q.zs_s2;

    // Monoflop: retriggered by each falling clock edge
    if (clk_fall) begin
      d.mono = TW'(sat_pkg::TM_CYC);
    end else if (q.mono != '0) begin
      d.mono = q.mono - TW'(1);
    end

    case (q.state)
      sat_pkg::LINK_IDLE: begin
        d.data = 1'b1;
        d.ring = 1'b0;
        d.gap = 1'b0;
        if (clk_fall) begin
          d.word = aligned;
          d.shreg = aligned;
          d.bitcnt = nbits;
          d.state = sat_pkg::LINK_SHIFT;
        end
      end
      sat_pkg::LINK_SHIFT: begin
        if (mono_done) begin
          d.data = 1'b1;
          d.state = sat_pkg::LINK_IDLE;
        end else if (clk_rise) begin
          d.data = q.shreg[31];
          d.shreg = {q.shreg[30:0], 1'b0};
          d.bitcnt = q.bitcnt - CW'(1);
          if (q.bitcnt == CW'(1)) begin
            d.gap = 1'b0;
            d.state = sat_pkg::LINK_TAIL;
          end
        end
      end
      sat_pkg::LINK_TAIL: begin
        if (mono_done) begin
          d.data = 1'b1;
          d.state = sat_pkg::LINK_IDLE;
        end else if (clk_rise) begin
          d.data = 1'b0;
          d.gap = 1'b1;
        end else if (clk_fall && q.gap) begin
          // Clocking went on without a pause: repeat the held word.
          // Only a fall after the low gap bit counts; the fall right
          // after the LSB must not, or every frame would start a ring.
          d.shreg = q.word;
          d.bitcnt = nbits;
          d.ring = 1'b1;
          d.state = sat_pkg::LINK_SHIFT;
        end
      end
      default: begin
        d.data = 1'b1;
        d.state = sat_pkg::LINK_IDLE;
      end
    endcase

    // Avalon slave: one wait state, then the access completes
    d.wait_n = req & ~q.wait_n;
    d.wreq = ~(req & ~q.wait_n);
    if (req && !q.wait_n) begin
      d.rdata = 32'h0;
      if (avs_address_i == sat_pkg::CTRL_OFS) begin
        d.rdata[sat_pkg::GRAY_BIT] = q.gray;
        d.rdata[sat_pkg::ST_LSB +: FW] = q.st_bits;
        d.rdata[sat_pkg::MT_LSB +: FW] = q.mt_bits;
      end else if (avs_address_i == sat_pkg::POS_OFS) begin
        d.rdata = pif.position;
      end else if (avs_address_i == sat_pkg::STAT_OFS) begin
        d.rdata[2:0] = q.state;
        d.rdata[3] = q.ring;
        d.rdata[4] = q.data;
        d.rdata[13:8] = nbits;
      end
    end
    if (acc && avs_write_i && avs_address_i == sat_pkg::CTRL_OFS) begin
      if (avs_byteenable_i[0]) begin
        d.gray = avs_writedata_i[sat_pkg::GRAY_BIT];
      end
      if (avs_byteenable_i[1]) begin
        d.st_bits = avs_writedata_i[sat_pkg::ST_LSB +: FW];
      end
      if (avs_byteenable_i[2]) begin
        d.mt_bits = avs_writedata_i[sat_pkg::MT_LSB +: FW];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.clk_s1 <= 1'b1;
      q.clk_s2 <= 1'b1;
      q.clk_s3 <= 1'b1;
      q.zs_s1 <= 1'b1;
      q.zs_s2 <= 1'b1;
      q.zs_s3 <= 1'b1;
      q.state <= sat_pkg::LINK_IDLE;
      q.data <= 1'b1;
      q.wreq <= 1'b1;
      q.gray <= sat_pkg::CTRL_GRAY_RST;
      q.st_bits <= sat_pkg::CTRL_ST_RST;
      q.mt_bits <= sat_pkg::CTRL_MT_RST;
    end else begin
      q <= d;
    end
  end

  assign ssi_data_o = q.data;
  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.wreq;
endmodule : sat_ssi_tx

// File: test/sat_ssi_tx_monitor.sv
// Purpose: port-level checks for the SSI position transmitter
// Assumes: link edges found by sampling the raw serial clock
// Notes: bounds allow for the design's input synchronisers
`timescale 1ns/1ps
module sat_ssi_tx_monitor (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ssi_clk_i,
  input wire logic ssi_data_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  logic clk_q;
  logic [3:0] rise_n;
  logic [11:0] high_n;
  wire req = avs_read_i || avs_write_i;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_q <= 1'h1;
      rise_n <= 4'hF;
      high_n <= 12'h0;
    end else begin
      clk_q <= ssi_clk_i;
      rise_n <= (ssi_clk_i && !clk_q) ? 4'h0 : rise_n + {3'h0, rise_n != 4'hF};
      high_n <= !ssi_clk_i ? 12'h0 : high_n + {11'h0, high_n != 12'hFFF};
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  chk_wait_one: assert property (
    req && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no accept");
  chk_accept_pulse: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("long accept");
  chk_wait_idle: assert property (
    !req |-> avs_waitrequest_o) else $error("accept without request");
  chk_unmapped_zero: assert property (
    avs_read_i && !avs_waitrequest_o &&
    !(avs_address_i inside {4'h0, 4'h4, 4'h8}) |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
    $changed(avs_readdata_o) |-> !avs_waitrequest_o) else $error("rdata moved");
  chk_fall_cause: assert property (
    $fell(ssi_data_o) |-> rise_n <= 4'h7) else $error("data fell off edge");
  chk_rise_cause: assert property (
    $rose(ssi_data_o) |-> rise_n <= 4'h7 || high_n >= sat_pkg::TM_CYC - 30)
    else $error("data rose early");
  chk_idle_high: assert property (
    high_n > sat_pkg::TM_CYC + 20 |-> ssi_data_o) else $error("idle low");
  cover property (avs_read_i && !avs_waitrequest_o);
  cover property ($fell(ssi_data_o));
  cover property ($rose(ssi_data_o) && high_n > 12'h700);
endmodule : sat_ssi_tx_monitor

// File: test/sat_ssi_master.sv
// Purpose: SSI master model issuing clock bundles
// Assumes: 125 ns link clock period
// Notes: bits taken at falling edges, MSB first
`timescale 1ns/1ps
module sat_ssi_master (
  output logic ssi_clk_o,
  input wire logic data_i
);
  initial ssi_clk_o = 1'h1; // Clock idles high
  task automatic xfer(int k, output logic [79:0] q);
    q = '0;
    wait (data_i === 1'b1); // No restart before data idles
    for (int i = 0; i <= k; i++) begin
      ssi_clk_o = 1'h0;
      if (i > 0)
        q = {q[78:0], data_i}; // Bit from previous rise
      #62.5; // Faster than the rated link to keep runs short
      ssi_clk_o = 1'h1;
      #62.5; // Half period far below the monoflop time
    end
  endtask : xfer
endmodule : sat_ssi_master

// File: test/tb_sat_ssi_tx.sv
// Purpose: self-checking bench for the SSI position transmitter
// Assumes: master model makes the serial clock
// Notes: step counts random from a fixed seed, directions random in the last two passes only
`timescale 1ns/1ps
module tb_sat_ssi_tx;
  logic clock_i = 1'h0, rstn_i = 1'h0, dir_sel_i = 1'h0, zero_set_i = 1'h1;
  logic step_i = 1'h0, cw_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
  logic avs_waitrequest_o, ssi_clk_i, ssi_data_o;
  logic [79:0] q;
  int n_fail = 0, n_compared = 0, pos = 0, nb = 25;
  bit gr = 1;
  sat_ssi_tx DUT (.clock_i, .rstn_i, .ssi_clk_i, .ssi_data_o, .dir_sel_i,
    .zero_set_i, .step_i, .cw_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o);
  sat_ssi_master m (.ssi_clk_o(ssi_clk_i), .data_i(ssi_data_o));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(string nm, logic [79:0] e, logic [79:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(bit w, logic [3:0] a, logic [31:0] d, logic [3:0] be);
    @(posedge clock_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do
      @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
  endtask : bus
  function automatic logic [31:0] bin();
    return 32'(pos) & 32'((64'h1 << nb) - 64'h1);
  endfunction : bin
  function automatic logic [79:0] wd();
    return 80'(gr ? bin() ^ (bin() >> 1) : bin());
  endfunction : wd
  task automatic steps(int k, bit rnd);
    bit c;
    repeat (k) begin
      c = rnd ? 1'($urandom_range(1)) : 1'b1;
      @(posedge clock_i);
      step_i <= 1'h1;
      cw_i <= c;
      @(posedge clock_i);
      step_i <= 1'h0;
      pos += (c ^ dir_sel_i) ? 1 : -1;
    end
  endtask : steps
  task automatic frame(int k, logic [79:0] e);
    #($urandom_range(90));
    m.xfer(k, q);
    chk("frame", e, q);
    #200 chk("tail", 1'h0, ssi_data_o); // Low after last bit
    #21000 chk("idle", 1'h1, ssi_data_o); // High after monoflop
  endtask : frame
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    #600000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h292c4e8c));
    repeat (6) @(posedge clock_i);
    rstn_i <= 1'h1;
    repeat (3) @(posedge clock_i); // Start-up wait shortened
    bus(1, 4'hC, 32'hFFFFFFFF, 4'hF);
    bus(0, 4'hC, 32'h0, 4'h0);
    chk("unmapped", 32'h0, rd);
    bus(0, 4'h0, 32'h0, 4'h0);
    chk("ctrl", 32'h000C0D01, rd); // Gray code by default
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        bus(1, 4'h0, 32'hFF1010FE, 4'h6);
        bus(1, 4'h0, 32'h0000FF00, 4'h1);
        bus(0, 4'h0, 32'h0, 4'h0);
        chk("ctrl", 32'h00101000, rd); // Widest word, binary
        gr = 0;
        nb = 32;
      end
      if (i == 3) begin
        @(posedge clock_i);
        dir_sel_i <= 1'h1;
        repeat (4) @(posedge clock_i);
      end
      steps($urandom_range(300, 100), i > 1);
      bus(0, 4'h4, 32'h0, 4'h0);
      chk("pos", bin(), rd); // Count sense
      #15000 frame(nb, wd()); // Fresh word
      frame(2 * nb + 1, (wd() << (nb + 1)) | wd()); // Repeat
    end
    @(posedge clock_i);
    zero_set_i <= 1'h0;
    repeat (6) @(posedge clock_i);
    bus(0, 4'h4, 32'h0, 4'h0);
    chk("zero", 32'h0, rd); // Zeroed count
    pos = 0;
    #15000 frame(nb, wd()); // All-zero word
    bus(0, 4'h8, 32'h0, 4'h0);
    chk("stat", 32'h11 | (32'(nb) << 8), rd); // Idle, data high
    report_and_stop();
  end
endmodule : tb_sat_ssi_tx
bind sat_ssi_tx sat_ssi_tx_monitor mon (.clock_i, .rstn_i, .ssi_clk_i,
  .ssi_data_o, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o);
